// ---- ttos_pkg.sv ----
// shared constants and carriers of the trigger output selector
package ttos_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int         AXI_AW      = 8;
  localparam int         AXI_DW      = 32;
  localparam logic [7:0] CTRL_OFF    = 8'h04;
  localparam logic [7:0] STAT_OFF    = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          SEL_LSB       = 4;
  localparam int          SEL_W         = 3;
  localparam logic [2:0]  SEL_RST_VAL   = 3'h0;
  localparam int          STAT_TRG_BIT  = 0;
  localparam int          STAT_RUN_BIT  = 1;
  localparam int          STAT_CNT_LSB  = 16;
  localparam int          CNT_W         = 16;
  localparam logic [15:0] CNT_RST_VAL   = 16'h0000;
  localparam logic [31:0] DATA_RST_VAL  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // trigger source settings
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_RESET  = 3'h0;
  localparam logic [2:0] SEL_ENABLE = 3'h1;
  localparam logic [2:0] SEL_UPDATE = 3'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic update_generate_bit;
    logic slave_reset;
    logic update_event;
  } ttos_evt_s;

  typedef struct packed {
    logic counter_run_bit;
    logic gated_mode;
    logic trigger_input;
  } ttos_run_s;

  typedef enum {WR_IDLE, WR_RESP} ttos_wr_e;
  typedef enum {RD_IDLE, RD_DATA} ttos_rd_e;

endpackage

// ---- ttos_sel.sv ----
// trigger source multiplexer with registered trigger output
`timescale 1ns/10ps
`default_nettype none
module ttos_sel
  import ttos_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic [SEL_W-1:0]      trigger_source_select,
  input  wire ttos_pkg::ttos_evt_s   evt,
  input  wire ttos_pkg::ttos_run_s   run,
  output logic                       trigger_output,
  output logic                       counter_run_signal
);

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic slave_reset_dly_r;
  logic run_nxt;
  logic reset_src;
  logic src_nxt;

  // gated mode lets the trigger input hold the counter running
  assign run_nxt   = run.counter_run_bit | (run.gated_mode & run.trigger_input);
  // slave reset reaches the output one stage late
  assign reset_src = evt.update_generate_bit | slave_reset_dly_r;

  always_comb begin
    case (trigger_source_select)
      SEL_RESET:  src_nxt = reset_src;
      SEL_ENABLE: src_nxt = run_nxt;
      SEL_UPDATE: src_nxt = evt.update_event;
      default:    src_nxt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slave_reset_dly_r  <= 1'b0;
      trigger_output     <= 1'b0;
      counter_run_signal <= 1'b0;
    end else begin
      slave_reset_dly_r  <= evt.slave_reset;
      trigger_output     <= src_nxt;
      counter_run_signal <= run_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- ttos_top.sv ----
// trigger output selector with its axi4-lite register slave
//
// Notes on behaviour
// - bits six to four hold a read/write trigger source select field
// - select 000 drives the trigger output from the update generate bit
// - select 000: slave-mode counter reset pulses the output, one cycle late
// - enable select drives the trigger output from the counter run signal
// - select 001; run signal is run bit OR trigger input in gated mode
// - select 010 drives the trigger output from the update event
`timescale 1ns/10ps
`default_nettype none
module ttos_top
  import ttos_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [AXI_DW-1:0]    s_axi_wdata,
  input  wire logic [AXI_DW/8-1:0]  s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [AXI_AW-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [AXI_DW-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // timer side
  input  wire ttos_pkg::ttos_evt_s  evt,
  input  wire ttos_pkg::ttos_run_s  run,
  output logic                      trigger_output,
  output logic                      counter_run_signal
);
  import ttos_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [AXI_AW-1:0] addr,
                                   input logic [AXI_AW-1:0] off);
    reg_hit = (addr[AXI_AW-1:2] == off[AXI_AW-1:2]);
  endfunction

  // both channels answer unmapped offsets the same way
  function automatic logic [1:0] resp_of(input logic mapped);
    resp_of = mapped ? RESP_OKAY : RESP_SLVERR;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ttos_wr_e          wr_state_r;
  ttos_wr_e          wr_state_nxt;
  ttos_rd_e          rd_state_r;
  ttos_rd_e          rd_state_nxt;
  logic              aw_held_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic              w_held_r;
  logic [AXI_DW-1:0] w_data_r;
  logic              w_strb0_r;
  logic [SEL_W-1:0]  sel_r;
  logic [SEL_W-1:0]  sel_nxt;
  logic [CNT_W-1:0]  pulse_cnt_r;
  logic [CNT_W-1:0]  pulse_cnt_nxt;
  logic              trg_seen;
  logic              run_seen;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire aw_have   = aw_held_r | aw_take;
  wire w_have    = w_held_r | w_take;
  wire [AXI_AW-1:0] wr_addr  = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [AXI_DW-1:0] wr_data  = w_held_r ? w_data_r : s_axi_wdata;
  wire              wr_strb0 = w_held_r ? w_strb0_r : s_axi_wstrb[0];
  // aw and w may arrive in either order; the later beat fires the write
  wire wr_fire   = (wr_state_r == WR_IDLE) & aw_have & w_have;
  wire wr_ctrl   = reg_hit(wr_addr, CTRL_OFF);
  wire wr_stat   = reg_hit(wr_addr, STAT_OFF);
  wire wr_mapped = wr_ctrl | wr_stat;
  wire b_done    = s_axi_bvalid & s_axi_bready;
  wire [1:0] wr_resp = resp_of(wr_mapped);

  // ----------------------------------------------------------------
  // write state
  // ----------------------------------------------------------------
  always_comb begin
    wr_state_nxt = wr_state_r;
    case (wr_state_r)
      WR_IDLE: begin
        if (wr_fire) begin
          wr_state_nxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (b_done) begin
          wr_state_nxt = WR_IDLE;
        end
      end
      default: wr_state_nxt = WR_IDLE;
    endcase
  end

  // only the select field is stored; everything else is dropped
  assign sel_nxt = (wr_fire & wr_ctrl & wr_strb0) ?
                   wr_data[SEL_LSB +: SEL_W] : sel_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_state_r <= WR_IDLE;
    end else begin
      wr_state_r <= wr_state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      w_held_r  <= 1'b0;
      w_data_r  <= DATA_RST_VAL;
      w_strb0_r <= 1'b0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (w_take) begin
      w_held_r  <= 1'b1;
      w_data_r  <= s_axi_wdata;
      w_strb0_r <= s_axi_wstrb[0];
    end
  end

  // ----------------------------------------------------------------
  // write ready and response
  // ----------------------------------------------------------------
  // ready is withdrawn once a beat is held, so nothing is overwritten
  wire aw_ready_nxt = (wr_state_nxt == WR_IDLE) & ~(aw_have & ~wr_fire);
  wire w_ready_nxt  = (wr_state_nxt == WR_IDLE) & ~(w_have & ~wr_fire);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= aw_ready_nxt;
      s_axi_wready  <= w_ready_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // a write without byte lane 0 keeps the old setting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sel_r <= SEL_RST_VAL;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // ----------------------------------------------------------------
  // trigger pulse counter
  // ----------------------------------------------------------------
  // a pulse in the clearing cycle still counts, so none is lost
  // the count wraps at its width; software must read it often enough
  wire cnt_clear = wr_fire & wr_stat;
  wire [CNT_W-1:0] cnt_base = cnt_clear ? CNT_RST_VAL : pulse_cnt_r;
  assign pulse_cnt_nxt = trigger_output ? (cnt_base + 16'h0001) : cnt_base;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_r <= CNT_RST_VAL;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  assign trg_seen = trigger_output;
  assign run_seen = counter_run_signal;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done  = s_axi_rvalid & s_axi_rready;
  wire rd_ctrl = reg_hit(s_axi_araddr, CTRL_OFF);
  wire rd_stat = reg_hit(s_axi_araddr, STAT_OFF);
  wire rd_mapped = rd_ctrl | rd_stat;
  wire [1:0] rd_resp = resp_of(rd_mapped);

  // ----------------------------------------------------------------
  // readback words
  // ----------------------------------------------------------------
  // reserved bits are tied low so no stale write data leaks back
  wire [AXI_DW-1:0] ctrl_word = AXI_DW'(sel_r) << SEL_LSB;
  wire [AXI_DW-1:0] stat_word = (AXI_DW'(pulse_cnt_r) << STAT_CNT_LSB)
                              | (AXI_DW'(run_seen) << STAT_RUN_BIT)
                              | (AXI_DW'(trg_seen) << STAT_TRG_BIT);
  wire [AXI_DW-1:0] rd_word   = rd_ctrl ? ctrl_word :
                                rd_stat ? stat_word : DATA_RST_VAL;

  // ----------------------------------------------------------------
  // read state
  // ----------------------------------------------------------------
  always_comb begin
    rd_state_nxt = rd_state_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (ar_take) begin
          rd_state_nxt = RD_DATA;
        end
      end
      RD_DATA: begin
        if (r_done) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: rd_state_nxt = RD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_state_r <= RD_IDLE;
    end else begin
      rd_state_r <= rd_state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read ready and response
  // ----------------------------------------------------------------
  // arready drops in the take cycle so no read slips in under rvalid
  wire ar_ready_nxt = (rd_state_nxt == RD_IDLE) & ~ar_take;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ar_ready_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= DATA_RST_VAL;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_resp;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // trigger selector
  // ----------------------------------------------------------------
  ttos_sel u_sel (
    .sys_clk               (sys_clk),
    .nrst                  (nrst),
    .trigger_source_select (sel_r),
    .evt                   (evt),
    .run                   (run),
    .trigger_output        (trigger_output),
    .counter_run_signal    (counter_run_signal)
  );

endmodule
`default_nettype wire

// ---- ttos_chk_sva.sv ----
// assertions on the trigger output selector ports
`timescale 1ns/10ps
`default_nettype none
module ttos_chk
  import ttos_pkg::*;
(
  input wire logic                s_axi_awvalid,
  input wire logic                sys_clk,
  input wire logic                nrst,
  input wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input wire logic                s_axi_awready,
  input wire logic [AXI_DW-1:0]   s_axi_wdata,
  input wire logic [AXI_DW/8-1:0] s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic [AXI_AW-1:0]   s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [AXI_DW-1:0]   s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire ttos_pkg::ttos_evt_s evt,
  input wire ttos_pkg::ttos_run_s run,
  input wire logic                trigger_output,
  input wire logic                counter_run_signal
);
  // shadow of the select field; beats may be taken in either order
  logic              aw_h_r;
  logic              w_h_r;
  logic              ws_h_r;
  logic [AXI_AW-1:0] aa_h_r;
  logic [SEL_W-1:0]  wd_h_r;
  logic [SEL_W-1:0]  sel_r;
  wire aw_t = s_axi_awvalid & s_axi_awready;
  wire w_t  = s_axi_wvalid & s_axi_wready;
  wire [AXI_AW-1:0] wa = aw_h_r ? aa_h_r : s_axi_awaddr;
  wire [SEL_W-1:0]  wd = w_h_r ? wd_h_r : s_axi_wdata[SEL_LSB +: SEL_W];
  wire              ws = w_h_r ? ws_h_r : s_axi_wstrb[0];
  wire fire   = (aw_h_r | aw_t) & (w_h_r | w_t);
  wire wr_ctl = fire & (wa[AXI_AW-1:2] == CTRL_OFF[AXI_AW-1:2]) & ws;
  wire run_eq = run.counter_run_bit | (run.gated_mode & run.trigger_input);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
      ws_h_r <= 1'b0;
      aa_h_r <= '0;
      wd_h_r <= '0;
      sel_r  <= SEL_RST_VAL;
    end else begin
      aw_h_r <= ~fire & (aw_h_r | aw_t);
      w_h_r  <= ~fire & (w_h_r | w_t);
      if (aw_t) begin
        aa_h_r <= s_axi_awaddr;
      end
      if (w_t) begin
        wd_h_r <= s_axi_wdata[SEL_LSB +: SEL_W];
        ws_h_r <= s_axi_wstrb[0];
      end
      if (wr_ctl) begin
        sel_r <= wd;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wctl;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == CTRL_OFF;
  endsequence
  sequence s_ctl_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_OFF;
  endsequence
  // sel must hold for the extra stage of the delayed reset pulse
  sequence s_slv;
    sel_r == SEL_RESET && evt.slave_reset ##1 sel_r == SEL_RESET;
  endsequence
  property p_ug; sel_r == SEL_RESET && evt.update_generate_bit |=> trigger_output; endproperty
  a_ug: assert property (p_ug) else $error("update generate not forwarded");
  property p_slv; s_slv |=> trigger_output; endproperty
  a_slv: assert property (p_slv) else $error("slave reset pulse missing");
  property p_en; sel_r == SEL_ENABLE |=> trigger_output == $past(run_eq); endproperty
  a_en: assert property (p_en) else $error("enable select wrong");
  property p_run; 1'b1 |=> counter_run_signal == $past(run_eq); endproperty
  a_run: assert property (p_run) else $error("run signal wrong");
  property p_upd; sel_r == SEL_UPDATE && evt.update_event |=> trigger_output; endproperty
  a_upd: assert property (p_upd) else $error("update event not forwarded");
  property p_quiet; sel_r == SEL_UPDATE && !evt.update_event |=> !trigger_output; endproperty
  a_quiet: assert property (p_quiet) else $error("trigger high without event");
  property p_other; sel_r > SEL_UPDATE |=> !trigger_output; endproperty
  a_other: assert property (p_other) else $error("unused select not low");
  property p_rd;
    s_ctl_rd |=> s_axi_rvalid && s_axi_rdata == {25'h0, $past(sel_r), 4'h0};
  endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_wr; s_wctl |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY; endproperty
  a_wr: assert property (p_wr) else $error("control write response wrong");
endmodule
bind ttos_top ttos_chk u_ttos_chk (.*);
`default_nettype wire

// ---- ttos_trg_rx.sv ----
// far side model: slave timer clocked by sys_clk, counting cycles with the trigger output high
`timescale 1ns/10ps
`default_nettype none
module ttos_trg_rx (
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  input  wire logic  trigger_output,
  output logic [15:0] trig_cnt_r
);
  // counts high cycles, so a held trigger is not mistaken for one pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) trig_cnt_r <= 16'h0000;
    else if (trigger_output) trig_cnt_r <= trig_cnt_r + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- test_timer_trigger_output_select.sv ----
// self-checking bench of the trigger output selector
`timescale 1ns/10ps
`default_nettype none
module test_timer_trigger_output_select;
  import ttos_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, rd_v;
  logic [1:0]  rs;
  logic [15:0] c0;
  ttos_evt_s   evt = '0;
  ttos_run_s   run = '0;
  wire logic   aw_ok, w_ok, b_v, ar_ok, r_v, trg, crs;
  wire logic [1:0]  b_rs, r_rs;
  wire logic [31:0] r_d;
  wire logic [15:0] rx_cnt;
  int n_fail = 0;
  int cmp_count = 0;
  always #25 sys_clk = ~sys_clk;
  ttos_top u_ttos_top (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_ok), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_v), .s_axi_wready(w_ok), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
    .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_ok), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .evt(evt), .run(run), .trigger_output(trg), .counter_run_signal(crs));
  ttos_trg_rx u_ttos_trg_rx (.sys_clk(sys_clk), .nrst(nrst), .trigger_output(trg),
    .trig_cnt_r(rx_cnt));
  task conclude;
    $display("counts: %0d compared, %0d failed", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tk;
    @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    tk;
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    for (i = 0; i < 40; i++) begin
      tk;
      if (aw_ok) aw_v <= 1'b0;
      if (w_ok) w_v <= 1'b0;
      if (b_v) break;
    end
    r = b_rs;
    b_rdy <= 1'b0;
    if (i == 40) begin
      n_fail++;
      conclude;
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    tk;
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    for (i = 0; i < 40; i++) begin
      tk;
      if (ar_ok) ar_v <= 1'b0;
      if (r_v) break;
    end
    d = r_d;
    r = r_rs;
    r_rdy <= 1'b0;
    if (i == 40) begin
      n_fail++;
      conclude;
    end
  endtask
  task t_reg;
    rd(CTRL_OFF, rd_v, rs);
    chk(rd_v, DATA_RST_VAL);
    chk(rs, RESP_OKAY);
    wr(CTRL_OFF, 32'hffff_ffff, rs);
    chk(rs, RESP_OKAY);
    rd(CTRL_OFF, rd_v, rs);
    chk(rd_v, 32'h0000_0070);
    wr(8'h40, 32'h0, rs);
    chk(rs, RESP_SLVERR);
    rd(CTRL_OFF, rd_v, rs);
    chk(rd_v, 32'h0000_0070);
    wr(CTRL_OFF, 32'h0, rs);
    rd(CTRL_OFF, rd_v, rs);
    chk(rd_v, 32'h0);
    $display("test reg done");
  endtask
  task t_sel0;
    tk;
    evt <= 3'b100;
    tk;
    evt <= 3'b000;
    tk;
    chk(trg, 1'b1);
    tk;
    chk(trg, 1'b0);
    evt <= 3'b010;
    tk;
    evt <= 3'b000;
    tk;
    chk(trg, 1'b0);
    tk;
    chk(trg, 1'b1);
    tk;
    chk(trg, 1'b0);
    $display("test reset select done");
  endtask
  task t_en;
    wr(CTRL_OFF, 32'h10, rs);
    for (int i = 0; i < 8; i++) begin
      tk;
      run <= i[2:0];
      tk;
      tk;
      chk(trg, i[2] | (i[1] & i[0]));
      chk(crs, i[2] | (i[1] & i[0]));
    end
    run <= '0;
    $display("test enable select done");
  endtask
  task t_upd;
    wr(CTRL_OFF, 32'h20, rs);
    c0 = rx_cnt;
    tk;
    evt <= 3'b001;
    tk;
    tk;
    tk;
    evt <= 3'b100;
    tk;
    evt <= 3'b000;
    chk(trg, 1'b1);
    tk;
    chk(trg, 1'b0);
    tk;
    chk(rx_cnt - c0, 16'h0003);
    // status count: cleared by a write, then one update pulse gives one high cycle
    wr(STAT_OFF, 32'h0, rs);
    chk(rs, RESP_OKAY);
    tk;
    evt <= 3'b001;
    tk;
    evt <= 3'b000;
    rd(STAT_OFF, rd_v, rs);
    chk(rd_v, 32'h0001_0000);
    // unused selects must stay silent whatever the events do
    for (int s = 3; s < 8; s++) begin
      wr(CTRL_OFF, s << 4, rs);
      tk;
      evt <= 3'b111;
      tk;
      evt <= 3'b000;
      tk;
      chk(trg, 1'b0);
      tk;
      chk(trg, 1'b0);
    end
    $display("test update select done");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reg;
    t_sel0;
    t_en;
    t_upd;
    conclude;
  end
endmodule
`default_nettype wire
